// file: seil_map.svh
`ifndef SEIL_MAP_SVH
`define SEIL_MAP_SVH

// Clock rate in kHz (250 MHz)
`define SEIL_CLK_KHZ        250000
// Debounce times in ms
`define SEIL_DEB_SHORT_MS   1
`define SEIL_DEB_LONG_MS    1000
// Clock output tri-state time after power-on, in ms
`define SEIL_TPOR_MS        6
// Start-up time for mirror load, in ms (0.1 s, refresh ~66 ms inside)
`define SEIL_TSTART_MS      100
// Derived cycle counts (exact products; longest fits in 32 bits)
`define SEIL_DEB_SHORT_CYC  (`SEIL_DEB_SHORT_MS * `SEIL_CLK_KHZ)
`define SEIL_DEB_LONG_CYC   (`SEIL_DEB_LONG_MS * `SEIL_CLK_KHZ)
`define SEIL_TPOR_CYC       (`SEIL_TPOR_MS * `SEIL_CLK_KHZ)
`define SEIL_TSTART_CYC     (`SEIL_TSTART_MS * `SEIL_CLK_KHZ)
// Switchover mode encodings
`define SEIL_BSM_DIRECT     2'h1
`define SEIL_BSM_LEVEL      2'h2
// Time stamp reset value
`define SEIL_STAMP_RST      8'h00
`define SEIL_HUND_RST       8'h00

`endif

// file: seil_pkg.sv
`default_nettype none
package seil_pkg;
    // Start-up sequence of the clock output and mirror load
    typedef enum logic [1:0] {
        SEIL_ST_HIZ,
        SEIL_ST_LOAD,
        SEIL_ST_RUN
    } seil_start_t;
    // Clock output gating states
    typedef enum logic [1:0] {
        SEIL_CK_OFF,
        SEIL_CK_SYNC,
        SEIL_CK_ON
    } seil_ck_t;
endpackage
`default_nettype wire

// file: seil_cnt.sv
`timescale 1ns/10ps
`default_nettype none
// Loadable down counter; done pulses when the count reaches zero
module seil_cnt (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        load_i,
    input  wire logic [31:0] value_i,
    output logic             busy_o,
    output logic             done_o
);
    logic [31:0] cnt_q; // Remaining cycles

    // Count down after a load
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q  <= 32'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (load_i) begin
            cnt_q  <= value_i;
            busy_o <= 1'b1;
            done_o <= 1'b0;
        end else if (busy_o) begin
            cnt_q  <= cnt_q - 32'h1;
            done_o <= (cnt_q == 32'h1);
            busy_o <= (cnt_q != 32'h1);
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: seil_stamp.sv
`timescale 1ns/10ps
`default_nettype none
// Temperature-high stamp store: count plus six time bytes
module seil_stamp (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        clear_i,
    input  wire logic        event_i,
    input  wire logic        overwrite_i,
    input  wire logic [47:0] time_i,
    output logic      [7:0]  count_o,
    output logic      [47:0] stamp_o
);
    `include "seil_map.svh"

    // Count always; stamp first event or every event
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_o <= `SEIL_STAMP_RST;
            stamp_o <= 48'h0;
        end else if (clear_i) begin
            count_o <= `SEIL_STAMP_RST;
            stamp_o <= 48'h0;
        end else if (event_i) begin
            count_o <= count_o + 8'h1;
            if (overwrite_i || count_o == 8'h00) begin
                stamp_o <= time_i;
            end
        end
    end
endmodule
`default_nettype wire

// file: seil_top.sv
// Behaviour
// - Clock halt stops high-temperature comparison
// - Seconds write or sync event clears hundredths
// - Threshold usable as storage when detection off
// - Overwrite selects stamp; counter always counts
// - Stamp reset clears stamps, flag; reads 0
// - High-clock-enable: high interrupt enables clock output
// - Delay high-temperature interrupt until clock output is on
// - Detect-enable rising edge starts high detection
// - Status write clears high and low flags
// - Switchover flag sets only in modes 01/10
// - Switchover enable gates interrupt output low
// - Flags sticky except power-on; enable gates; no re-trigger
// - Interrupt releases when flag cleared
// - Return to main: debounce 1 or 1000 ms
// - Power-on startup sets flag, may interrupt
// - Enable mirror loaded after 0.1 s start-up
// - Supply below reset level clears power flag
// - Clock output Hi-Z 6 ms, low, then sync
// - Once-per-second sample sets voltage-low flag
// - Voltage-low flag clears only by software
// - Low voltage: stop compensation, clock low, bus off
// - Voltage-low enable lives in nonvolatile byte
// - Stamp reset releases interrupt output
`timescale 1ns/10ps
`default_nettype none
module seil_top (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        tick_1hz_i,
    input  wire logic        clock_halt_i,
    input  wire logic        temp_above_i,
    input  wire logic        temp_below_i,
    input  wire logic        temp_high_detect_en_i,
    input  wire logic        temp_high_irq_en_i,
    input  wire logic        temp_high_overwrite_i,
    input  wire logic        temp_high_stamp_reset_i,
    input  wire logic        temp_high_clock_out_en_i,
    input  wire logic        irq_delay_en_i,
    input  wire logic [47:0] time_i,
    input  wire logic        seconds_wr_i,
    input  wire logic        event_sync_en_i,
    input  wire logic        event_input_pin_i,
    input  wire logic        status_wr_i,
    input  wire logic        temp_low_set_i,
    input  wire logic [1:0]  switchover_mode_i,
    input  wire logic        switchover_irq_en_i,
    input  wire logic        on_backup_i,
    input  wire logic        por_level_ok_i,
    input  wire logic        nv_power_on_irq_en_i,
    input  wire logic        nv_volt_low_irq_en_i,
    input  wire logic        volt_low_i,
    input  wire logic        flag_clr_high_i,
    input  wire logic        flag_clr_switch_i,
    input  wire logic        flag_clr_power_i,
    input  wire logic        flag_clr_volt_i,
    input  wire logic        clk_out_req_i,
    input  wire logic        clk_sync_i,
    output logic             temp_high_flag_o,
    output logic             temp_low_flag_o,
    output logic             switchover_flag_o,
    output logic             power_on_flag_o,
    output logic             volt_low_flag_o,
    output logic             power_on_irq_en_o,
    output logic             volt_low_irq_en_o,
    output logic             temp_high_stamp_reset_o,
    output logic [7:0]       temp_high_count_o,
    output logic [47:0]      temp_high_stamp_o,
    output logic             hund_clear_o,
    output logic             event_sync_clr_o,
    output logic             comp_run_o,
    output logic             bus_enable_o,
    output logic             irq_n_o,
    output logic             irq_n_oe_o,
    output logic             clock_output_pin_o,
    output logic             clock_output_pin_oe_o
);
    import seil_pkg::*;
    `include "seil_map.svh"

    seil_start_t st_q;          // Start-up phase
    seil_ck_t    ck_q;          // Clock output gate state
    logic        det_en_q;      // Delayed detect enable
    logic        det_arm_q;     // High detection armed
    logic        bak_q;         // Delayed backup state
    logic        por_q;         // Delayed reset level
    logic        deb_load;      // Debounce start
    logic        deb_busy;      // Debounce running
    logic        st_load;       // Start-up timer start
    logic        st_done;       // Start-up phase done
    logic [31:0] st_val;        // Start-up phase length
    logic        high_evt;      // New high-temperature event
    logic        irq_any;       // Any gated source pending
    logic        src_high;      // High source for interrupt

    // Debounce timer for return to main supply
    seil_cnt u_deb (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .load_i  (deb_load),
        .value_i (volt_low_flag_o ? `SEIL_DEB_LONG_CYC
                                  : `SEIL_DEB_SHORT_CYC),
        .busy_o  (deb_busy),
        .done_o  ()
    );

    // Start-up timer, shared by tri-state and mirror load phases
    seil_cnt u_st (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .load_i  (st_load),
        .value_i (st_val),
        .busy_o  (),
        .done_o  (st_done)
    );

    // High-temperature stamp store
    seil_stamp u_stamp (
        .mclk_i      (mclk_i),
        .nrst_i      (nrst_i),
        .clear_i     (temp_high_stamp_reset_i),
        .event_i     (high_evt),
        .overwrite_i (temp_high_overwrite_i),
        .time_i      (time_i),
        .count_o     (temp_high_count_o),
        .stamp_o     (temp_high_stamp_o)
    );

    // Edge trackers for enables and supply states
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            det_en_q <= 1'b0;
            bak_q    <= 1'b0;
            por_q    <= 1'b0;
        end else begin
            det_en_q <= temp_high_detect_en_i;
            bak_q    <= on_backup_i;
            por_q    <= por_level_ok_i;
        end
    end

    // Detection arms only on a 0 to 1 enable edge
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            det_arm_q <= 1'b0;
        end else if (!temp_high_detect_en_i) begin
            det_arm_q <= 1'b0;
        end else if (!det_en_q) begin
            det_arm_q <= 1'b1;
        end
    end

    // Comparison runs on the tick, not while halted or low
    assign high_evt = det_arm_q && tick_1hz_i && !clock_halt_i
                    && !volt_low_i && temp_above_i;

    // High flag: set beats software clears; reset and status clear
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            temp_high_flag_o <= 1'b0;
        end else if (high_evt && temp_high_irq_en_i) begin
            temp_high_flag_o <= 1'b1;
        end else if (temp_high_stamp_reset_i || status_wr_i
                     || flag_clr_high_i) begin
            temp_high_flag_o <= 1'b0;
        end
    end

    // Low flag only cleared here; set comes from outside
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            temp_low_flag_o <= 1'b0;
        end else if (temp_low_set_i) begin
            temp_low_flag_o <= 1'b1;
        end else if (status_wr_i) begin
            temp_low_flag_o <= 1'b0;
        end
    end

    // Stamp reset always reads back as zero
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            temp_high_stamp_reset_o <= 1'b0;
        end else begin
            temp_high_stamp_reset_o <= 1'b0;
        end
    end

    // Hundredths clear on seconds write or synced event
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hund_clear_o     <= 1'b0;
            event_sync_clr_o <= 1'b0;
        end else begin
            hund_clear_o <= seconds_wr_i
                || (event_sync_en_i && event_input_pin_i);
            event_sync_clr_o <= event_sync_en_i && event_input_pin_i;
        end
    end

    // Switchover flag: sets on main-to-backup in mode 01 or 10
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            switchover_flag_o <= 1'b0;
        end else if (on_backup_i && !bak_q
                     && (switchover_mode_i == `SEIL_BSM_DIRECT
                      || switchover_mode_i == `SEIL_BSM_LEVEL)) begin
            switchover_flag_o <= 1'b1;
        end else if (flag_clr_switch_i) begin
            switchover_flag_o <= 1'b0;
        end
    end

    // Debounce starts when backup returns to main
    assign deb_load = bak_q && !on_backup_i;

    // Power-on flag: set on rise above reset level, clear on fall
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            power_on_flag_o <= 1'b0;
        end else if (por_level_ok_i && !por_q) begin
            power_on_flag_o <= 1'b1;
        end else if (!por_level_ok_i) begin
            power_on_flag_o <= 1'b0;
        end else if (flag_clr_power_i) begin
            power_on_flag_o <= 1'b0;
        end
    end

    // Voltage-low flag: sampled at 1 Hz, software clear only
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            volt_low_flag_o <= 1'b0;
        end else if (tick_1hz_i && volt_low_i) begin
            volt_low_flag_o <= 1'b1;
        end else if (flag_clr_volt_i) begin
            volt_low_flag_o <= 1'b0;
        end
    end

    // Start-up sequence: tri-state, then mirror load
    always_comb begin
        st_load = 1'b0;
        st_val  = `SEIL_TPOR_CYC;
        if (!por_level_ok_i) begin
            st_load = 1'b0;
        end else if (!por_q) begin
            st_load = 1'b1;
        end else if (st_q == SEIL_ST_HIZ && st_done) begin
            st_load = 1'b1;
            st_val  = `SEIL_TSTART_CYC - `SEIL_TPOR_CYC;
        end
    end

    // Phase register; mirrors load once start-up completes
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q              <= SEIL_ST_HIZ;
            power_on_irq_en_o <= 1'b0;
            volt_low_irq_en_o <= 1'b0;
        end else if (!por_level_ok_i) begin
            st_q              <= SEIL_ST_HIZ;
            power_on_irq_en_o <= 1'b0;
        end else begin
            case (st_q)
                SEIL_ST_HIZ: begin
                    if (st_done) begin
                        st_q <= SEIL_ST_LOAD;
                    end
                end
                SEIL_ST_LOAD: begin
                    if (st_done) begin
                        st_q              <= SEIL_ST_RUN;
                        power_on_irq_en_o <= nv_power_on_irq_en_i;
                        volt_low_irq_en_o <= nv_volt_low_irq_en_i;
                    end
                end
                SEIL_ST_RUN: begin
                    volt_low_irq_en_o <= nv_volt_low_irq_en_i;
                end
                default: st_q <= SEIL_ST_HIZ;
            endcase
        end
    end

    // Clock output: off, waiting for sync edge, or on
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ck_q <= SEIL_CK_OFF;
        end else if (st_q == SEIL_ST_HIZ || volt_low_i) begin
            ck_q <= SEIL_CK_OFF;
        end else begin
            case (ck_q)
                SEIL_CK_OFF: begin
                    if (clk_out_req_i || (temp_high_clock_out_en_i
                                          && src_high)) begin
                        ck_q <= SEIL_CK_SYNC;
                    end
                end
                SEIL_CK_SYNC: begin
                    if (clk_sync_i) begin
                        ck_q <= SEIL_CK_ON;
                    end
                end
                SEIL_CK_ON: begin
                    if (!clk_out_req_i && !(temp_high_clock_out_en_i
                                            && src_high)) begin
                        ck_q <= SEIL_CK_OFF;
                    end
                end
                default: ck_q <= SEIL_CK_OFF;
            endcase
        end
    end

    // Pin driver: Hi-Z during reset window, low when gated off
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clock_output_pin_o    <= 1'b0;
            clock_output_pin_oe_o <= 1'b1;
        end else begin
            clock_output_pin_oe_o <= (st_q == SEIL_ST_HIZ);
            clock_output_pin_o    <= (ck_q == SEIL_CK_ON) && clk_sync_i;
        end
    end

    // Bus off under low voltage, backup or debounce; compensation off under low voltage or halt
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            comp_run_o   <= 1'b0;
            bus_enable_o <= 1'b0;
        end else begin
            comp_run_o   <= !volt_low_i && !clock_halt_i;
            bus_enable_o <= !volt_low_i && !deb_busy
                            && !deb_load && !on_backup_i;
        end
    end

    // High source waits for clock output when delay is set
    assign src_high = temp_high_flag_o && temp_high_irq_en_i;
    assign irq_any  = (src_high && (!irq_delay_en_i
                                    || ck_q == SEIL_CK_ON))
                    || (switchover_flag_o && switchover_irq_en_i)
                    || (power_on_flag_o && power_on_irq_en_o)
                    || (volt_low_flag_o && volt_low_irq_en_o);

    // Open-drain interrupt: enable low while pulling low
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_n_o    <= 1'b1;
            irq_n_oe_o <= 1'b1;
        end else begin
            irq_n_o    <= !irq_any;
            irq_n_oe_o <= !irq_any || temp_high_stamp_reset_i;
        end
    end

    // Interrupt releases the cycle after every flag is down
    a_irq_release: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        !(temp_high_flag_o || switchover_flag_o || power_on_flag_o
          || volt_low_flag_o) |=> irq_n_oe_o) else $error("irq held low");
    // Switchover flag only rises in mode 01 or 10
    a_switch_mode: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        $rose(switchover_flag_o) |-> ^$past(switchover_mode_i))
        else $error("switchover in off mode");
    // Voltage flag stays unless software clears
    a_volt_sticky: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        $fell(volt_low_flag_o) |-> $past(flag_clr_volt_i))
        else $error("volt flag self-cleared");
    // Status write clears high flag without event
    a_status_clr: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        (status_wr_i && !high_evt) |=> !temp_high_flag_o)
        else $error("status write ignored");
    // Falling below reset level clears power flag
    a_por_clear: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        (!por_level_ok_i) |=> !power_on_flag_o)
        else $error("power flag kept");
    // No new count while halted, unless the stamp reset clears it
    a_halt_stop: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        (clock_halt_i && !temp_high_stamp_reset_i)
        |=> $stable(temp_high_count_o)) else $error("event while halted");
    // Clock low under low voltage
    a_low_clk: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        volt_low_i |=> ##1 !clock_output_pin_o)
        else $error("clock output under low voltage");
    // Bus off during debounce
    a_deb_bus: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        deb_busy |=> !bus_enable_o) else $error("bus on in debounce");
endmodule
`default_nettype wire

// file: seil_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host model: sets up the high-temperature enables and issues the
// one-cycle register writes that the device sees as strobes.
module seil_host (
    input  wire logic       mclk_i,
    output logic            detect_en_o,
    output logic            irq_en_o,
    output logic      [5:0] wr_o
);
    // Strobes: 0 status, 1 stamp reset, 2..5 clear high/switch/power/volt
    initial begin
        detect_en_o = 1'h0;
        irq_en_o    = 1'h0;
        wr_o        = 6'h00;
    end
    // Set-up with detection dropped first, so no stray event fires
    task automatic arm(input logic en);
        @(posedge mclk_i);
        detect_en_o <= 1'h0;
        irq_en_o    <= en;
        @(posedge mclk_i);
        detect_en_o <= 1'h1;
    endtask
    // Interrupt enable alone, detection left as it is
    task automatic gate(input logic en);
        @(posedge mclk_i);
        irq_en_o <= en;
    endtask
    // One write, held for exactly one clock
    task automatic write(input int idx);
        @(posedge mclk_i);
        wr_o[idx] <= 1'h1;
        @(posedge mclk_i);
        wr_o <= 6'h00;
    endtask
endmodule
`default_nettype wire

// file: seil_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module seil_top_tb;
    import seil_pkg::*;
    // One switchover case: inputs, then expected flag and pin
    typedef struct packed {
        logic [1:0] mode;
        logic       en;
        logic       flag;
        logic       irq_n;
    } seil_row_t;
    seil_row_t        rows [8];
    logic             mclk_i, nrst_i, halt, above, ovw, sync_en;
    logic             backup, por_ok, vlow, nv, sw_en;
    logic             ck_en, dly, ck_req, ck_sync; // Clock gate inputs
    logic [1:0]       mode;
    logic [3:0]       strb;    // Tick, seconds, event, low temp
    logic [47:0]      tm;
    int               fails, checked;
    wire logic        th_flag, tl_flag, sw_flag, po_flag, vl_flag, po_en;
    wire logic        st_rst, hund, comp, bus_en, irq_n, irq_oe;
    wire logic        det_en, irq_en, vl_en, sync_clr, ck_pin, ck_oe;
    wire logic [7:0]  cnt;
    wire logic [47:0] stamp;
    wire logic [5:0]  wr;

    seil_host seil_host_inst (.mclk_i(mclk_i), .detect_en_o(det_en),
        .irq_en_o(irq_en), .wr_o(wr));
    seil_top seil_top_inst (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .tick_1hz_i(strb[0]),
        .clock_halt_i(halt), .temp_above_i(above), .temp_below_i(1'h0),
        .temp_high_detect_en_i(det_en), .temp_high_irq_en_i(irq_en),
        .temp_high_overwrite_i(ovw), .temp_high_stamp_reset_i(wr[1]),
        .temp_high_clock_out_en_i(ck_en), .irq_delay_en_i(dly),
        .time_i(tm), .seconds_wr_i(strb[1]), .event_sync_en_i(sync_en),
        .event_input_pin_i(strb[2]), .status_wr_i(wr[0]),
        .temp_low_set_i(strb[3]), .switchover_mode_i(mode),
        .switchover_irq_en_i(sw_en), .on_backup_i(backup),
        .por_level_ok_i(por_ok), .nv_power_on_irq_en_i(nv),
        .nv_volt_low_irq_en_i(nv), .volt_low_i(vlow),
        .flag_clr_high_i(wr[2]), .flag_clr_switch_i(wr[3]),
        .flag_clr_power_i(wr[4]), .flag_clr_volt_i(wr[5]),
        .clk_out_req_i(ck_req), .clk_sync_i(ck_sync),
        .temp_high_flag_o(th_flag), .temp_low_flag_o(tl_flag),
        .switchover_flag_o(sw_flag), .power_on_flag_o(po_flag),
        .volt_low_flag_o(vl_flag), .power_on_irq_en_o(po_en),
        .volt_low_irq_en_o(vl_en), .temp_high_stamp_reset_o(st_rst),
        .temp_high_count_o(cnt), .temp_high_stamp_o(stamp),
        .hund_clear_o(hund), .event_sync_clr_o(sync_clr), .comp_run_o(comp),
        .bus_enable_o(bus_en), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe),
        .clock_output_pin_o(ck_pin), .clock_output_pin_oe_o(ck_oe));

    // Free-running 250 MHz clock
    initial begin
        mclk_i = 1'h0;
        forever #2 mclk_i = ~mclk_i;
    end
    // Verdict and end of run, the only exit
    task automatic close_out();
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Single-bit result
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Counter and stamp values
    task automatic chkv(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Let n edges pass, then look once their updates have landed
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // One-cycle pulse on a bench strobe
    task automatic strobe(input int idx);
        @(posedge mclk_i);
        strb[idx] <= 1'h1;
        @(posedge mclk_i);
        strb[idx] <= 1'h0;
    endtask
    // Short mid-run reset; a reset clears every sticky flag
    task automatic rst();
        @(posedge mclk_i);
        nrst_i <= 1'h0;
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1'h1;
    endtask
    // Hang guard: far beyond the sequence length
    initial begin
        #200000;
        fails++;
        close_out();
    end

    initial begin
        {nrst_i, halt, above, ovw, sync_en, backup, vlow, sw_en} = 8'h00;
        {por_ok, nv, mode, strb, tm, fails, checked} = '0;
        por_ok = 1'h1;
        nv = 1'h1;
        // High source may request the clock; Hi-Z phase must still win
        {ck_en, dly, ck_req, ck_sync} = 4'h8;
        // Mode 00 and 11 must never raise the flag
        rows = '{'{2'h0, 1'h0, 1'h0, 1'h1}, '{2'h0, 1'h1, 1'h0, 1'h1},
                 '{2'h1, 1'h0, 1'h1, 1'h1}, '{2'h1, 1'h1, 1'h1, 1'h0},
                 '{2'h2, 1'h0, 1'h1, 1'h1}, '{2'h2, 1'h1, 1'h1, 1'h0},
                 '{2'h3, 1'h0, 1'h0, 1'h1}, '{2'h3, 1'h1, 1'h0, 1'h1}};
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'h1;
        wait_n(4);
        chk1(po_flag, 1'h1);
        chk1(po_en, 1'h0);
        chk1(irq_n, 1'h1);
        chk1(vl_en, 1'h0);
        chk1(ck_oe, 1'h1);
        por_ok <= 1'h0;
        wait_n(3);
        chk1(po_flag, 1'h0);
        por_ok <= 1'h1;
        // Flag rises with the supply, then software clears it
        seil_host_inst.write(4);
        wait_n(2);
        chk1(po_flag, 1'h0);
        foreach (rows[i]) begin
            @(posedge mclk_i);
            {mode, sw_en} <= {rows[i].mode, rows[i].en};
            backup <= 1'h0;
            rst();
            wait_n(2);
            backup <= 1'h1;
            wait_n(4);
            chk1(sw_flag, rows[i].flag);
            chk1(irq_n, rows[i].irq_n);
        end
        // High-temperature event: flag, count, stamp, pin
        backup <= 1'h0;
        rst();
        seil_host_inst.arm(1'h1);
        tm <= 48'h0A0B0C0D0E0F;
        above <= 1'h1;
        strobe(0);
        wait_n(2);
        chk1(th_flag, 1'h1);
        chkv(cnt, 48'h1);
        chkv(stamp, 48'h0A0B0C0D0E0F);
        chk1(irq_n, 1'h0);
        // Delay set: clock output never came on, so no interrupt
        dly <= 1'h1;
        wait_n(3);
        chk1(irq_n, 1'h1);
        dly <= 1'h0;
        ovw <= 1'h1;
        tm <= 48'h111213141516;
        strobe(0);
        wait_n(2);
        chkv(cnt, 48'h2);
        chkv(stamp, 48'h111213141516);
        chk1(irq_n, 1'h0);
        seil_host_inst.gate(1'h0);
        wait_n(3);
        chk1(irq_n, 1'h1);
        seil_host_inst.gate(1'h1);
        wait_n(3);
        chk1(irq_n, 1'h0);
        strobe(3);
        wait_n(2);
        chk1(tl_flag, 1'h1);
        seil_host_inst.write(0);
        wait_n(3);
        chk1(th_flag, 1'h0);
        chk1(tl_flag, 1'h0);
        chk1(irq_n, 1'h1);
        strobe(0);
        wait_n(2);
        chkv(cnt, 48'h3);
        seil_host_inst.write(1);
        #1;
        chk1(irq_oe, 1'h1);
        wait_n(3);
        chkv(cnt, 48'h0);
        chkv(stamp, 48'h0);
        chk1(th_flag, 1'h0);
        chk1(st_rst, 1'h0);
        chk1(irq_oe, 1'h1);
        // Halted clock: comparison suspended
        halt <= 1'h1;
        strobe(0);
        wait_n(2);
        chkv(cnt, 48'h0);
        chk1(th_flag, 1'h0);
        {halt, above} <= 2'h0;
        // Hundredths clear on seconds write or synced event only
        strobe(1);
        #1;
        chk1(hund, 1'h1);
        sync_en <= 1'h1;
        strobe(2);
        #1;
        chk1(hund, 1'h1);
        chk1(sync_clr, 1'h1);
        sync_en <= 1'h0;
        strobe(2);
        #1;
        chk1(hund, 1'h0);
        chk1(sync_clr, 1'h0);
        // Low supply: bus off, compensation off, sticky flag
        vlow <= 1'h1;
        wait_n(3);
        chk1(bus_en, 1'h0);
        chk1(comp, 1'h0);
        strobe(0);
        wait_n(2);
        chk1(vl_flag, 1'h1);
        vlow <= 1'h0;
        strobe(0);
        wait_n(3);
        chk1(vl_flag, 1'h1);
        seil_host_inst.write(5);
        wait_n(2);
        chk1(vl_flag, 1'h0);
        // Clock requested and sync running, but still in the Hi-Z phase
        {ck_req, ck_sync} <= 2'h3;
        wait_n(3);
        chk1(ck_pin, 1'h0);
        chk1(ck_oe, 1'h1);
        close_out();
    end
endmodule
`default_nettype wire
